/* File: inc/rst_pkg.sv */
package rst_pkg;
  // Pin group widths
  localparam int HIGH_W = 11;
  localparam int LOW_W  = 5;
  localparam int S01_W  = 3;
  localparam int S10_W  = 2;
  localparam int BA_W   = 2;
  localparam int ADDR_W = 21;
  localparam int GPA_W  = 6;
  localparam int GPA_LO = 15;
  localparam int Z_W    = 49;
  localparam int WAKE_BIT = 48;
  localparam int SRC_W  = 4;
  localparam int SEL_W  = 2;
  localparam int IRQ_W  = 3;

  // Reset levels of each pin group
  localparam logic [HIGH_W-1:0] HIGH_RST = 11'h7FF;
  localparam logic [LOW_W-1:0]  LOW_RST  = 5'h00;
  localparam logic [S01_W-1:0]  S01_RST  = 3'h0;
  localparam logic [S01_W-1:0]  S01_REL  = 3'h7;
  localparam logic [S10_W-1:0]  S10_RST  = 2'h3;
  localparam logic [S10_W-1:0]  S10_REL  = 2'h0;
  localparam logic [BA_W-1:0]   BA_RST   = 2'h3;
  localparam logic              FLAG_RST = 1'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;
  localparam logic [Z_W-1:0]    Z_OE_RST = 49'h0;

  // Synchronised pin vector fields
  localparam int SYN_W   = 6;
  localparam int SYN_RST = 0;
  localparam int SYN_I0  = 1;
  localparam int SYN_I1  = 2;
  localparam int SYN_WK  = 3;
  localparam int SYN_REF = 4;
  localparam int SYN_RTC = 5;
  localparam logic [SYN_W-1:0] SYN_IDLE = 6'h0F;

  // Timing, in system clock periods
  localparam int RST_LOW_PERIODS  = 3;
  localparam int INT_LOW_PERIODS  = 2;
  localparam int LIGHT_WAKE_PERIODS = 3;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] RST_CNT_MAX =
    CNT_W'(RST_LOW_PERIODS - 1);
  localparam logic [CNT_W-1:0] LIGHT_CNT_MAX =
    CNT_W'(LIGHT_WAKE_PERIODS - 1);

  typedef enum logic [2:0] {
    ST_RESET, ST_BOOT, ST_RUN, ST_LIGHT, ST_LIGHT_WAKE,
    ST_DEEP, ST_DEEP_EDGE, ST_DEEP_PERIOD
  } pm_state_t;
endpackage

/* File: inc/sync_if.sv */
`timescale 1ns/100ps
interface sync_if;
  logic [rst_pkg::SYN_W-1:0] raw;
  logic [rst_pkg::SYN_W-1:0] synced;
  modport user (output raw, input synced);
  modport sync (input raw, output synced);
endinterface

/* File: hdl/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync (
  input  wire logic clk_in,
  input  wire logic rst_in,
  sync_if.sync      port
);
  logic [rst_pkg::SYN_W-1:0] meta_q;
  logic [rst_pkg::SYN_W-1:0] meta_d;
  logic [rst_pkg::SYN_W-1:0] stable_q;
  logic [rst_pkg::SYN_W-1:0] stable_d;

  always_comb begin
    meta_d   = port.raw;
    stable_d = meta_q;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q   <= rst_pkg::SYN_IDLE;
      stable_q <= rst_pkg::SYN_IDLE;
    end else begin
      meta_q   <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign port.synced = stable_q;
endmodule

/* File: hdl/reset_pin_state_and_idle_wake.sv */
`timescale 1ns/100ps
// Operation
// - After hardware reset, enable clock generator and start boot in the same cycle.
// - Outside reset, pins follow selected peripheral; fixed in reset, except clock observe and display select one.
// - In reset drive chip selects, masks, enables, select, strobes high.
// - In reset drive read enable, read/write, card and SDRAM clocks low.
// - In reset release data, emulation, two-wire, card, test, wake pins.
// - In reset keep clock observe and display select one toggling.
// - Select zero, write line, clock enable low in reset, high after.
// - SDRAM chip selects high in reset, low at release.
// - Bank address and flag output settle synchronously high.
// - Memory address bus settles synchronously low.
// - Light idle resumes clocks three periods after an interrupt.
// - Any unmasked interrupt leaves light idle.
// - External interrupts and RTC interrupt wake both idle states.
// - Deep idle bypasses generator using reference or RTC clock.
// - Each external and RTC interrupt source has its own enable; the internal interrupt has none.
// - Clock observe output follows one of four selected sources.
// - Reset pin applies hardware reset; software reset is separate.
module reset_pin_state_and_idle_wake (
  input  wire logic                        clk_in,
  input  wire logic                        rst_in,
  input  wire logic                        reset_pin_n_in,
  input  wire logic [1:0]                  ext_int_pin_n_in,
  input  wire logic                        external_reference_clock_in,
  input  wire logic                        rtc_oscillator_clock_in,
  input  wire logic                        rtc_irq_in,
  input  wire logic                        internal_irq_in,
  input  wire logic [rst_pkg::IRQ_W-1:0]   int_enable_in,
  input  wire logic                        bus_pin_selection_register_in,
  input  wire logic                        reference_select_in,
  input  wire logic                        system_clock_disable_bit_in,
  input  wire logic                        light_idle_req_in,
  input  wire logic                        deep_idle_req_in,
  input  wire logic [rst_pkg::SEL_W-1:0]   clock_source_sel_in,
  input  wire logic [rst_pkg::SRC_W-1:0]   clock_source_tick_in,
  input  wire logic [rst_pkg::HIGH_W-1:0]  fn_high_in,
  input  wire logic [rst_pkg::LOW_W-1:0]   fn_low_in,
  input  wire logic                        fn_display_cs_one_in,
  input  wire logic [rst_pkg::S01_W-1:0]   fn_sync01_in,
  input  wire logic [rst_pkg::S10_W-1:0]   fn_sdram_cs_in,
  input  wire logic [rst_pkg::BA_W-1:0]    fn_bank_in,
  input  wire logic                        fn_flag_in,
  input  wire logic [rst_pkg::ADDR_W-1:0]  fn_addr_in,
  input  wire logic [rst_pkg::GPA_W-1:0]   gpio_addr_in,
  input  wire logic [rst_pkg::Z_W-1:0]     fn_z_out_in,
  input  wire logic [rst_pkg::Z_W-1:0]     fn_z_oe_in,
  input  wire logic [rst_pkg::Z_W-1:0]     z_pins_in,
  output logic [rst_pkg::HIGH_W-1:0]       high_group_out,
  output logic [rst_pkg::LOW_W-1:0]        low_group_out,
  output logic                             clock_observe_out,
  output logic                             display_chip_select_one_out,
  output logic [rst_pkg::S01_W-1:0]        sync01_group_out,
  output logic [rst_pkg::S10_W-1:0]        sdram_chip_select_out,
  output logic [rst_pkg::BA_W-1:0]         sdram_bank_address_out,
  output logic                             general_flag_output_out,
  output logic [rst_pkg::ADDR_W-1:0]       ext_memory_address_bus_out,
  output logic [rst_pkg::Z_W-1:0]          z_pins_out,
  output logic [rst_pkg::Z_W-1:0]          z_pins_oe_out,
  output logic                             clock_gen_enable_out,
  output logic                             clock_bypass_out,
  output logic                             clock_bypass_ref_out,
  output logic                             boot_start_out,
  output logic                             cpu_clock_run_out,
  output logic [1:0]                       int_request_out,
  output logic                             in_reset_out
);
  sync_if sif ();

  pin_sync u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .port   (sif.sync)
  );

  assign sif.raw = {rtc_oscillator_clock_in, external_reference_clock_in,
                    z_pins_in[rst_pkg::WAKE_BIT], ext_int_pin_n_in,
                    reset_pin_n_in};

  // Reset pin filter and release
  logic [rst_pkg::CNT_W-1:0] rlow_q;
  logic [rst_pkg::CNT_W-1:0] rlow_d;
  logic                      pin_rst_q;
  logic                      pin_rst_d;
  logic                      in_rst;
  logic                      in_rst_q;
  logic                      release_pulse;

  always_comb begin
    rlow_d    = '0;
    pin_rst_d = pin_rst_q;
    if (!sif.synced[rst_pkg::SYN_RST]) begin
      rlow_d = (rlow_q == rst_pkg::RST_CNT_MAX) ? rlow_q
               : rlow_q + 1'b1;
      if (rlow_q == rst_pkg::RST_CNT_MAX)
        pin_rst_d = 1'b1;
    end else begin
      pin_rst_d = 1'b0;
    end
  end

  assign in_rst        = rst_in | pin_rst_q;
  assign release_pulse = in_rst_q & ~in_rst;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rlow_q    <= '0;
      pin_rst_q <= 1'b0;
      in_rst_q  <= 1'b1;
    end else begin
      rlow_q    <= rlow_d;
      pin_rst_q <= pin_rst_d;
      in_rst_q  <= in_rst;
    end
  end

  // Interrupt qualification
  logic [1:0] ilow_q;
  logic [1:0] ilow_d;
  logic [1:0] ihigh_q;
  logic [1:0] ihigh_d;
  logic [1:0] iarm_q;
  logic [1:0] iarm_d;
  logic [1:0] ireq_q;
  logic [1:0] ireq_d;
  logic [1:0] pin_low;
  logic [1:0] qual_low;

  assign pin_low = ~sif.synced[rst_pkg::SYN_I1:rst_pkg::SYN_I0];

  always_comb begin
    ilow_d   = pin_low;
    ihigh_d  = ~pin_low;
    iarm_d   = iarm_q;
    ireq_d   = '0;
    qual_low = pin_low & ilow_q;
    for (int i = 0; i < 2; i++) begin
      if (~pin_low[i] && ihigh_q[i])
        iarm_d[i] = 1'b1;
      if (qual_low[i] && iarm_q[i]) begin
        iarm_d[i] = 1'b0;
        ireq_d[i] = int_enable_in[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (in_rst) begin
      ilow_q  <= '0;
      ihigh_q <= '0;
      iarm_q  <= '0;
      ireq_q  <= '0;
    end else begin
      ilow_q  <= ilow_d;
      ihigh_q <= ihigh_d;
      iarm_q  <= iarm_d;
      ireq_q  <= ireq_d;
    end
  end

  // Power state machine
  rst_pkg::pm_state_t       st_q;
  rst_pkg::pm_state_t       st_d;
  logic [rst_pkg::CNT_W-1:0] wcnt_q;
  logic [rst_pkg::CNT_W-1:0] wcnt_d;
  logic                      ref_q;
  logic                      ref_d;
  logic                      ref_level;
  logic                      ref_rise;
  logic                      wake_evt;
  logic                      light_evt;
  logic                      deep_evt;
  logic                      run_d;
  logic                      gen_d;
  logic                      byp_d;

  assign ref_level = reference_select_in ? sif.synced[rst_pkg::SYN_REF]
                     : sif.synced[rst_pkg::SYN_RTC];
  assign ref_rise  = ref_level & ~ref_q;

  always_comb begin
    wake_evt  = (qual_low[0] & int_enable_in[0])
              | (qual_low[1] & int_enable_in[1])
              | (rtc_irq_in & int_enable_in[2]);
    light_evt = wake_evt | ireq_q[0] | ireq_q[1]
              | internal_irq_in;
    deep_evt  = wake_evt
              | (~sif.synced[rst_pkg::SYN_WK] & system_clock_disable_bit_in);
    ref_d  = ref_level;
    st_d   = st_q;
    wcnt_d = '0;
    case (st_q)
      rst_pkg::ST_RESET: st_d = rst_pkg::ST_BOOT;
      rst_pkg::ST_BOOT:  st_d = rst_pkg::ST_RUN;
      rst_pkg::ST_RUN: begin
        if (deep_idle_req_in)
          st_d = rst_pkg::ST_DEEP;
        else if (light_idle_req_in)
          st_d = rst_pkg::ST_LIGHT;
      end
      rst_pkg::ST_LIGHT: begin
        if (light_evt)
          st_d = rst_pkg::ST_LIGHT_WAKE;
      end
      rst_pkg::ST_LIGHT_WAKE: begin
        wcnt_d = wcnt_q + 1'b1;
        if (wcnt_q == rst_pkg::LIGHT_CNT_MAX)
          st_d = rst_pkg::ST_RUN;
      end
      rst_pkg::ST_DEEP: begin
        if (deep_evt)
          st_d = system_clock_disable_bit_in ? rst_pkg::ST_DEEP_EDGE
                 : rst_pkg::ST_RUN;
      end
      rst_pkg::ST_DEEP_EDGE: begin
        if (ref_rise)
          st_d = rst_pkg::ST_DEEP_PERIOD;
      end
      rst_pkg::ST_DEEP_PERIOD: begin
        if (ref_rise)
          st_d = rst_pkg::ST_RUN;
      end
      default: st_d = rst_pkg::ST_RESET;
    endcase
    if (in_rst)
      st_d = rst_pkg::ST_RESET;
    run_d = (st_d == rst_pkg::ST_RUN);
    byp_d = (st_d == rst_pkg::ST_DEEP) || (st_d == rst_pkg::ST_DEEP_EDGE)
         || (st_d == rst_pkg::ST_DEEP_PERIOD);
    gen_d = ~in_rst & ~byp_d;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q                 <= rst_pkg::ST_RESET;
      wcnt_q               <= '0;
      ref_q                <= 1'b0;
      cpu_clock_run_out    <= 1'b0;
      clock_gen_enable_out <= 1'b0;
      clock_bypass_out     <= 1'b0;
    end else begin
      st_q                 <= st_d;
      wcnt_q               <= wcnt_d;
      ref_q                <= ref_d;
      cpu_clock_run_out    <= run_d;
      clock_gen_enable_out <= gen_d;
      clock_bypass_out     <= byp_d;
    end
  end

  // Pin groups
  logic                        obs_q;
  logic                        obs_d;
  logic [rst_pkg::HIGH_W-1:0]  high_d;
  logic [rst_pkg::LOW_W-1:0]   low_d;
  logic                        cs1_d;
  logic [rst_pkg::S01_W-1:0]   s01_d;
  logic [rst_pkg::S10_W-1:0]   s10_d;
  logic [rst_pkg::BA_W-1:0]    ba_d;
  logic                        flag_d;
  logic [rst_pkg::ADDR_W-1:0]  addr_d;
  logic [rst_pkg::Z_W-1:0]     zo_d;
  logic [rst_pkg::Z_W-1:0]     zoe_d;

  always_comb begin
    obs_d = obs_q ^ clock_source_tick_in[clock_source_sel_in];
    high_d = fn_high_in;
    low_d  = fn_low_in;
    cs1_d  = fn_display_cs_one_in;
    s01_d  = fn_sync01_in;
    s10_d  = fn_sdram_cs_in;
    ba_d   = fn_bank_in;
    flag_d = fn_flag_in;
    addr_d = fn_addr_in;
    if (bus_pin_selection_register_in)
      addr_d[rst_pkg::GPA_LO +: rst_pkg::GPA_W] = gpio_addr_in;
    zo_d  = fn_z_out_in;
    zoe_d = fn_z_oe_in;
    if (in_rst) begin
      high_d = rst_pkg::HIGH_RST;
      low_d  = rst_pkg::LOW_RST;
      zoe_d  = rst_pkg::Z_OE_RST;
      cs1_d  = obs_d;
      s01_d  = rst_pkg::S01_RST;
      s10_d  = rst_pkg::S10_RST;
      ba_d   = rst_pkg::BA_RST;
      flag_d = rst_pkg::FLAG_RST;
      addr_d = rst_pkg::ADDR_RST;
    end else if (release_pulse) begin
      s01_d  = rst_pkg::S01_REL;
      s10_d  = rst_pkg::S10_REL;
      ba_d   = rst_pkg::BA_RST;
      flag_d = rst_pkg::FLAG_RST;
      addr_d = rst_pkg::ADDR_RST;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      obs_q                       <= 1'b0;
      clock_observe_out           <= 1'b0;
      high_group_out              <= rst_pkg::HIGH_RST;
      low_group_out               <= rst_pkg::LOW_RST;
      display_chip_select_one_out <= 1'b0;
      sync01_group_out            <= rst_pkg::S01_RST;
      sdram_chip_select_out       <= rst_pkg::S10_RST;
      sdram_bank_address_out      <= rst_pkg::BA_RST;
      general_flag_output_out     <= rst_pkg::FLAG_RST;
      ext_memory_address_bus_out  <= rst_pkg::ADDR_RST;
      z_pins_out                  <= '0;
      z_pins_oe_out               <= rst_pkg::Z_OE_RST;
      clock_bypass_ref_out        <= 1'b0;
      boot_start_out              <= 1'b0;
      int_request_out             <= '0;
      in_reset_out                <= 1'b1;
    end else begin
      obs_q                       <= obs_d;
      clock_observe_out           <= obs_d;
      high_group_out              <= high_d;
      low_group_out               <= low_d;
      display_chip_select_one_out <= cs1_d;
      sync01_group_out            <= s01_d;
      sdram_chip_select_out       <= s10_d;
      sdram_bank_address_out      <= ba_d;
      general_flag_output_out     <= flag_d;
      ext_memory_address_bus_out  <= addr_d;
      z_pins_out                  <= zo_d;
      z_pins_oe_out               <= zoe_d;
      clock_bypass_ref_out        <= reference_select_in;
      boot_start_out              <= release_pulse;
      int_request_out             <= ireq_d;
      in_reset_out                <= in_rst;
    end
  end
endmodule

/* File: tb/rst_monitor.sv */
`timescale 1ns/100ps
module rst_monitor (
  input wire logic                        clk_in,
  input wire logic                        rst_in,
  input wire logic                        in_reset_out,
  input wire logic [rst_pkg::HIGH_W-1:0]  high_group_out,
  input wire logic [rst_pkg::LOW_W-1:0]   low_group_out,
  input wire logic [rst_pkg::Z_W-1:0]     z_pins_oe_out,
  input wire logic [rst_pkg::S01_W-1:0]   sync01_group_out,
  input wire logic [rst_pkg::S10_W-1:0]   sdram_chip_select_out,
  input wire logic [rst_pkg::BA_W-1:0]    sdram_bank_address_out,
  input wire logic                        general_flag_output_out,
  input wire logic [rst_pkg::ADDR_W-1:0]  ext_memory_address_bus_out,
  input wire logic                        boot_start_out,
  input wire logic                        clock_gen_enable_out,
  input wire logic                        clock_observe_out,
  input wire logic                        display_chip_select_one_out,
  input wire logic [1:0]                  int_request_out,
  input wire logic                        clock_bypass_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic held_q;
  logic held;
  always_ff @(posedge clk_in) held_q <= in_reset_out && !rst_in;
  assign held = in_reset_out && held_q;
  AST_HIGH_GRP: assert property (
    held |-> high_group_out == rst_pkg::HIGH_RST)
    else $error("high group not high in reset");
  AST_LOW_GRP: assert property (
    held |-> low_group_out == rst_pkg::LOW_RST)
    else $error("low group not low in reset");
  AST_Z_GRP: assert property (
    held |-> z_pins_oe_out == rst_pkg::Z_OE_RST)
    else $error("z group driven in reset");
  AST_SYNC_HOLD: assert property (
    held |-> sync01_group_out == 3'h0 && sdram_chip_select_out == 2'h3)
    else $error("sync groups wrong in reset");
  AST_SYNC_REL: assert property (
    $fell(in_reset_out) |-> ##[0:3]
      (sync01_group_out == 3'h7 && sdram_chip_select_out == 2'h0))
    else $error("sync groups not released");
  AST_BANK_FLAG: assert property (
    held |-> sdram_bank_address_out == 2'h3 && general_flag_output_out)
    else $error("bank or flag not high in reset");
  AST_ADDR_LOW: assert property (
    held |-> ext_memory_address_bus_out == 21'h000000)
    else $error("address not low in reset");
  AST_BOOT: assert property (
    boot_start_out |-> clock_gen_enable_out && !in_reset_out
      ##1 !boot_start_out)
    else $error("boot pulse wrong");
  AST_OBS_PAIR: assert property (
    held |-> display_chip_select_one_out == clock_observe_out)
    else $error("select one not following observe clock");
  AST_INT_PULSE: assert property (
    int_request_out[0] |=> !int_request_out[0])
    else $error("interrupt request longer than one cycle");
  cover property (boot_start_out);
  cover property (int_request_out[1]);
  cover property ($rose(clock_bypass_out));
endmodule

bind reset_pin_state_and_idle_wake rst_monitor u_mon (.clk_in, .rst_in,
  .in_reset_out, .high_group_out, .low_group_out, .z_pins_oe_out,
  .sync01_group_out, .sdram_chip_select_out, .sdram_bank_address_out,
  .general_flag_output_out, .ext_memory_address_bus_out, .boot_start_out,
  .clock_gen_enable_out, .clock_observe_out, .display_chip_select_one_out,
  .int_request_out, .clock_bypass_out);

/* File: tb/board_source.sv */
`timescale 1ns/100ps
module board_source (
  input  wire logic       clk_in,
  output logic            reset_pin_n_out,
  output logic [1:0]      int_pin_n_out,
  output logic            ref_clk_out,
  output logic            rtc_clk_out
);
  initial begin
    reset_pin_n_out = 1'b1;
    int_pin_n_out = 2'h3;
    ref_clk_out = 1'b0;
    rtc_clk_out = 1'b0;
  end
  // Reset pin low for n periods
  task automatic reset_low(input int n);
    @(posedge clk_in);
    reset_pin_n_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    reset_pin_n_out <= 1'b1;
  endtask
  // Request low n periods, then high 4 periods
  task automatic int_low(input int i, input int n);
    @(posedge clk_in);
    int_pin_n_out[i] <= 1'b0;
    repeat (n) @(posedge clk_in);
    int_pin_n_out[i] <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask
  // Slow clock runs only here, each level 3 periods
  task automatic ref_edges(input logic rtc, input int n);
    repeat (2 * n) begin
      repeat (3) @(posedge clk_in);
      if (rtc)
        rtc_clk_out <= ~rtc_clk_out;
      else
        ref_clk_out <= ~ref_clk_out;
    end
  endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  logic        clk_in, rst_in, rtc_irq_in, internal_irq_in, fn_flag_in;
  logic        bus_pin_selection_register_in, reference_select_in;
  logic        system_clock_disable_bit_in, light_idle_req_in;
  logic        deep_idle_req_in, fn_display_cs_one_in, reset_pin_n_in;
  logic        external_reference_clock_in, rtc_oscillator_clock_in;
  logic        clock_observe_out, display_chip_select_one_out;
  logic        general_flag_output_out, clock_gen_enable_out;
  logic        clock_bypass_out, clock_bypass_ref_out, boot_start_out;
  logic        cpu_clock_run_out, in_reset_out;
  logic [1:0]  ext_int_pin_n_in, int_request_out, clock_source_sel_in;
  logic [1:0]  fn_sdram_cs_in, fn_bank_in, sdram_chip_select_out;
  logic [1:0]  sdram_bank_address_out;
  logic [2:0]  int_enable_in, fn_sync01_in, sync01_group_out;
  logic [3:0]  clock_source_tick_in;
  logic [4:0]  fn_low_in, low_group_out;
  logic [5:0]  gpio_addr_in;
  logic [10:0] fn_high_in, high_group_out;
  logic [20:0] fn_addr_in, ext_memory_address_bus_out;
  logic [48:0] fn_z_out_in, fn_z_oe_in, z_pins_in, z_pins_out, z_pins_oe_out;
  int          n_errors, n_compared;

  reset_pin_state_and_idle_wake u_dut (.clk_in, .rst_in, .reset_pin_n_in,
    .ext_int_pin_n_in, .external_reference_clock_in, .rtc_oscillator_clock_in,
    .rtc_irq_in, .internal_irq_in, .int_enable_in,
    .bus_pin_selection_register_in, .reference_select_in,
    .system_clock_disable_bit_in, .light_idle_req_in, .deep_idle_req_in,
    .clock_source_sel_in, .clock_source_tick_in, .fn_high_in, .fn_low_in,
    .fn_display_cs_one_in, .fn_sync01_in, .fn_sdram_cs_in, .fn_bank_in,
    .fn_flag_in, .fn_addr_in, .gpio_addr_in, .fn_z_out_in, .fn_z_oe_in,
    .z_pins_in, .high_group_out, .low_group_out, .clock_observe_out,
    .display_chip_select_one_out, .sync01_group_out, .sdram_chip_select_out,
    .sdram_bank_address_out, .general_flag_output_out,
    .ext_memory_address_bus_out, .z_pins_out, .z_pins_oe_out,
    .clock_gen_enable_out, .clock_bypass_out, .clock_bypass_ref_out,
    .boot_start_out, .cpu_clock_run_out, .int_request_out, .in_reset_out);
  board_source u_src (.clk_in, .reset_pin_n_out(reset_pin_n_in),
    .int_pin_n_out(ext_int_pin_n_in),
    .ref_clk_out(external_reference_clock_in),
    .rtc_clk_out(rtc_oscillator_clock_in));

  task automatic complete_run();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return in_reset_out;
      1: return boot_start_out;
      default: return cpu_clock_run_out;
    endcase
  endfunction
  task automatic wait_for(input int w, input logic v, output int k);
    k = 0;
    while (sig(w) !== v) begin
      @(posedge clk_in);
      k++;
      if (k > 60) begin
        n_errors++;
        $display("wrong value at %0t: wait ran out", $time);
        complete_run();
      end
    end
  endtask
  task automatic levels();
    chk(high_group_out, 11'h7FF);
    chk(low_group_out, 5'h00);
    chk(z_pins_oe_out, 49'h0);
    chk(sync01_group_out, 3'h0);
    chk(sdram_chip_select_out, 2'h3);
    chk({sdram_bank_address_out, general_flag_output_out}, 3'h7);
    chk(ext_memory_address_bus_out, 21'h000000);
  endtask
  task automatic t_observe(input int s);
    int n;
    logic last;
    for (int p = 0; p < 2; p++) begin
      clock_source_sel_in <= 2'(s);
      clock_source_tick_in <= p ? 4'h1 << s : ~(4'h1 << s);
      repeat (3) @(posedge clk_in);
      n = 0;
      last = clock_observe_out;
      repeat (6) begin
        @(posedge clk_in);
        if (clock_observe_out !== last) n++;
        last = clock_observe_out;
      end
      chk(p ? n >= 4 : n == 0, 1'b1);
    end
    clock_source_tick_in <= 4'h0;
  endtask
  task automatic t_reset();
    int          k;
    logic [20:0] exp_addr;
    fork
      u_src.reset_low(30);
    join_none
    wait_for(0, 1'b1, k);
    repeat (2) @(posedge clk_in);
    levels();
    t_observe(0);
    wait_for(1, 1'b1, k);
    chk(sync01_group_out, 3'h7);
    chk(sdram_chip_select_out, 2'h0);
    chk(clock_gen_enable_out, 1'b1);
    for (int b = 1; b >= 0; b--) begin
      bus_pin_selection_register_in <= b[0];
      repeat (2) @(posedge clk_in);
      exp_addr = {b ? gpio_addr_in : fn_addr_in[20:15], fn_addr_in[14:0]};
      chk(ext_memory_address_bus_out, exp_addr);
    end
    chk(high_group_out, fn_high_in);
    chk(low_group_out, fn_low_in);
    chk(sync01_group_out, fn_sync01_in);
    chk(sdram_chip_select_out, fn_sdram_cs_in);
    chk(sdram_bank_address_out, fn_bank_in);
    chk(general_flag_output_out, fn_flag_in);
    chk(display_chip_select_one_out, fn_display_cs_one_in);
    chk(z_pins_out, fn_z_out_in);
    chk(z_pins_oe_out, fn_z_oe_in);
    u_src.reset_low(1);
    repeat (12) begin
      @(posedge clk_in);
      chk(in_reset_out, 1'b0);
    end
    $display("reset test done");
  endtask
  task automatic t_int();
    int n;
    for (int e = 0; e < 2; e++)
      for (int i = 0; i < 2; i++) begin
        int_enable_in <= 3'(e << i);
        n = 0;
        fork
          repeat (2) u_src.int_low(i, 3);
          repeat (24) begin
            @(posedge clk_in);
            if (int_request_out[i] === 1'b1) n++;
          end
        join
        chk(n, 2 * e);
      end
    $display("interrupt test done");
  endtask
  task automatic t_light();
    int k;
    int_enable_in <= 3'h7;
    for (int w = 0; w < 4; w++) begin
      light_idle_req_in <= 1'b1;
      @(posedge clk_in);
      light_idle_req_in <= 1'b0;
      wait_for(2, 1'b0, k);
      fork
        if (w < 2) u_src.int_low(w, 3);
      join_none
      rtc_irq_in <= w == 2;
      internal_irq_in <= w == 3;
      wait_for(2, 1'b1, k);
      chk(k >= 3 && k <= 14, 1'b1);
      rtc_irq_in <= 1'b0;
      internal_irq_in <= 1'b0;
      repeat (8) @(posedge clk_in);
    end
    $display("light idle test done");
  endtask
  task automatic t_deep();
    int k;
    for (int r = 0; r < 2; r++) begin
      reference_select_in <= r[0];
      system_clock_disable_bit_in <= 1'b1;
      deep_idle_req_in <= 1'b1;
      @(posedge clk_in);
      deep_idle_req_in <= 1'b0;
      wait_for(2, 1'b0, k);
      repeat (2) @(posedge clk_in);
      chk(clock_bypass_out, 1'b1);
      chk(clock_bypass_ref_out, r[0]);
      chk(clock_gen_enable_out, 1'b0);
      z_pins_in[48] <= 1'b0;
      repeat (20) @(posedge clk_in);
      chk(cpu_clock_run_out, 1'b0);
      u_src.ref_edges(!r[0], 2);
      wait_for(2, 1'b1, k);
      z_pins_in[48] <= 1'b1;
      system_clock_disable_bit_in <= 1'b0;
      repeat (8) @(posedge clk_in);
    end
    // Deep idle with clock kept, woken by the RTC interrupt
    deep_idle_req_in <= 1'b1;
    @(posedge clk_in);
    deep_idle_req_in <= 1'b0;
    wait_for(2, 1'b0, k);
    rtc_irq_in <= 1'b1;
    wait_for(2, 1'b1, k);
    rtc_irq_in <= 1'b0;
    chk(k, 2);
    repeat (4) @(posedge clk_in);
    $display("deep idle test done");
  endtask

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    rst_in = 1'b1;
    {rtc_irq_in, internal_irq_in, light_idle_req_in, deep_idle_req_in} = 4'h0;
    {reference_select_in, system_clock_disable_bit_in} = 2'h0;
    bus_pin_selection_register_in = 1'b1;
    int_enable_in = 3'h0;
    clock_source_sel_in = 2'h0;
    clock_source_tick_in = 4'h0;
    {fn_high_in, fn_low_in, fn_sync01_in} = {11'h2A5, 5'h15, 3'h2};
    {fn_sdram_cs_in, fn_bank_in, fn_flag_in} = {2'h1, 2'h2, 1'h0};
    fn_display_cs_one_in = 1'b1;
    fn_addr_in = 21'h0A5A5A;
    gpio_addr_in = 6'h2D;
    fn_z_out_in = 49'h1_2345_6789_ABCD;
    fn_z_oe_in = 49'h0_FFFF_0000_FFFF;
    z_pins_in = 49'h1_0000_0000_0000;
    repeat (19) @(posedge clk_in);
    levels();
    @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    t_reset();
    for (int s = 0; s < 4; s++) t_observe(s);
    $display("observe test done");
    t_int();
    t_light();
    t_deep();
    complete_run();
  end
endmodule
